//--- idr_intx_swizzle.sv
// idr_intx_swizzle: folds downstream port message intx onto routed lines a..d
`timescale 1ns/1ns
`default_nettype none
module idr_intx_swizzle (
  // per port intx a..d and attach state
  input  wire logic [idr_pkg::IDR_NPORT-1:0][3:0] msgIntx,
  input  wire logic [idr_pkg::IDR_NPORT-1:0]      present,
  // routed lines a..d
  output logic [3:0]                              lineAbcd
);
  import idr_pkg::*;

  always_comb begin
    lineAbcd = '0;
    for (int p = 0; p < IDR_NPORT; p++) begin
      for (int i = 0; i < 4; i++) begin
        // an empty port has no function, so stale messages are dropped
        if (present[p] && msgIntx[p][i]) begin
          lineAbcd[2'(IDR_PORT_BASE[p] + 2'(i))] = 1'b1;
        end
      end
    end
  end

endmodule // idr_intx_swizzle
`default_nettype wire

//--- idr_io_decode_irq_router.sv
// idr_io_decode_irq_router: io/memory cycle decode and legacy/apic irq routing
//
// Notes on behaviour
// - unclaimed io cycles go subtractively to pci, never to the lpc bus.
// - only io windows 3F8-3FF, 3E8-3EF, A00-A0F are claimed for lpc.
// - io CF8-CFB decodes as pci configuration address, never general use.
// - io CFC-CFF decodes as pci configuration data, never general use.
// - memory A0000-BFFFF goes to video memory and firmware, not dram.
// - legacy mode inputs 3-7 and 10-12 take serial irq or pci lines.
// - inputs 0,1,2,8,9,13 belong to fixed owners only.
// - legacy mode steers each routed line to any free legacy input.
// - apic mode delivers routed lines a-h on inputs 16-23 only.
// - line a drives 16 with graphics, root ports 0,4, second ehci.
// - line b drives 17 with root ports 1 and 5.
// - line c drives 18 with root port 2 and smbus host.
// - line d drives 19 with root ports 3,7, graphics root, both sata.
// - lines e, g, h drive 20, 22, 23 with lan, audio, first ehci.
// - intx a lands on the port's base line per downstream port.
// - intx b, c, d rotate cyclically after the base line.
// - a downstream port function is visible only when a device is attached.
`timescale 1ns/1ns
`default_nettype none
module idr_io_decode_irq_router (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // host cycles
  input  wire idr_pkg::idr_cycle_t    cycle,
  output logic                        decodeValid,
  output idr_pkg::idr_target_t        decodeTgt,
  // interrupt pins from outside
  input  wire logic [15:0]            serialIrqLine,
  input  wire logic [7:0]             routedPciLine,
  // on-chip interrupt sources
  input  wire idr_pkg::idr_fixed_irq_t fixedIrq,
  input  wire idr_pkg::idr_func_irq_t  funcIrq,
  input  wire logic [7:0][3:0]        msgIntx,
  // legacy steering target per routed line a..h
  input  wire logic [7:0][3:0]        pciSteer,
  // downstream ports
  input  wire logic [7:0]             portPresent,
  output logic [7:0]                  portVisible,
  // mode strap and state
  input  wire logic                   apicStrap,
  output logic                        apicActive,
  output logic                        modeLocked,
  // interrupt controller inputs
  output logic [23:0]                 irqOut
);
  import idr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers for everything arriving from pins
  logic [15:0] serialMeta;
  logic [15:0] serialS;
  logic [7:0]  pinMeta;
  logic [7:0]  pinS;
  logic        strapMeta;
  logic        strapS;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serialMeta <= '0;
      serialS    <= '0;
      pinMeta    <= '0;
      pinS       <= '0;
      strapMeta  <= 1'b0;
      strapS     <= 1'b0;
    end else begin
      serialMeta <= serialIrqLine;
      serialS    <= serialMeta;
      pinMeta    <= routedPciLine;
      pinS       <= pinMeta;
      strapMeta  <= apicStrap;
      strapS     <= strapMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode strap: taken once the synchroniser holds a post-reset sample

  idr_mode_t  mode;
  logic [1:0] strapCnt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strapCnt   <= '0;
      modeLocked <= 1'b0;
      mode       <= IDR_RST_MODE;
      apicActive <= (IDR_RST_MODE == IDR_MODE_APIC);
    end else if (!modeLocked) begin
      if (strapCnt == IDR_STRAP_DLY) begin
        // after this only a reset changes the mode again
        modeLocked <= 1'b1;
        mode       <= strapS ? IDR_MODE_APIC : IDR_MODE_LEGACY;
        apicActive <= strapS;
      end else begin
        strapCnt <= strapCnt + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle decode

  idr_target_t next_tgt;

  idr_io_decoder uDecode (
    .cyc (cycle),
    .tgt (next_tgt)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      decodeValid <= 1'b0;
      decodeTgt   <= '0;
    end else begin
      decodeValid <= cycle.valid;
      decodeTgt   <= next_tgt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // downstream port visibility

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      portVisible <= '0;
    end else begin
      portVisible <= portPresent;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // routed line levels a..h

  logic [3:0] swzAbcd;
  logic [7:0] lineLevel;

  idr_intx_swizzle uSwizzle (
    .msgIntx  (msgIntx),
    .present  (portPresent),
    .lineAbcd (swzAbcd)
  );

  always_comb begin
    lineLevel    = pinS;
    lineLevel[0] = pinS[0] | funcIrq.gfx | funcIrq.rp0 | funcIrq.rp4
                 | funcIrq.ehci2 | swzAbcd[0];
    lineLevel[1] = pinS[1] | funcIrq.rp1 | funcIrq.rp5 | swzAbcd[1];
    lineLevel[2] = pinS[2] | funcIrq.rp2 | funcIrq.smbus | swzAbcd[2];
    lineLevel[3] = pinS[3] | funcIrq.rp3 | funcIrq.rp7 | funcIrq.pegRoot
                 | funcIrq.sata1 | funcIrq.sata2 | swzAbcd[3];
    lineLevel[4] = pinS[4] | funcIrq.lan;
    lineLevel[6] = pinS[6] | funcIrq.hda;
    lineLevel[7] = pinS[7] | funcIrq.ehci1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fixed owners and legacy steering

  logic [15:0] fixedVec;
  logic [15:0] pciPic;

  always_comb begin
    fixedVec                  = '0;
    fixedVec[IDR_IRQ_TIMER]   = fixedIrq.timer;
    fixedVec[IDR_IRQ_KBD]     = fixedIrq.kbd;
    fixedVec[IDR_IRQ_CASCADE] = fixedIrq.cascade;
    fixedVec[IDR_IRQ_RTC]     = fixedIrq.rtc;
    fixedVec[IDR_IRQ_ACPI]    = fixedIrq.acpiControlInterrupt;
    fixedVec[IDR_IRQ_MATH]    = fixedIrq.math;
  end

  always_comb begin
    pciPic = '0;
    for (int l = 0; l < IDR_NLINE; l++) begin
      if (lineLevel[l]) begin
        pciPic[pciSteer[l]] = 1'b1;
      end
    end
    // a steering value that names an owned input is silently dropped
    pciPic = pciPic & ~IDR_PIC_RESERVED;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt controller inputs

  logic [23:0] next_irq;

  always_comb begin
    next_irq       = '0;
    next_irq[15:0] = fixedVec | (serialS & IDR_PIC_SHARED);
    if (mode == IDR_MODE_APIC) begin
      // pci lines reach only the upper inputs in this mode
      next_irq[23:IDR_APIC_BASE] = lineLevel;
    end else begin
      next_irq[15:0] = next_irq[15:0] | pciPic;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqOut <= '0;
    end else begin
      irqOut <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cbChk @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic pastIo;
  assign pastIo = cycle.valid && cycle.isIo;

  property p_subtractive;
    (pastIo && !idr_lpc_hit(cycle.addr[15:0])
     && !idr_in16(cycle.addr[15:0], IDR_CFGA_LO, IDR_CFGD_HI))
    |=> decodeTgt.pciSub && !decodeTgt.lpc;
  endproperty
  a_subtractive: assert property (p_subtractive)
    else $error("unclaimed io cycle not sent to pci");

  property p_lpc_only;
    decodeTgt.lpc |-> $past(pastIo) && idr_lpc_hit($past(cycle.addr[15:0]))
                      && !decodeTgt.pciSub;
  endproperty
  a_lpc_only: assert property (p_lpc_only)
    else $error("lpc claimed outside its windows");

  property p_cfg_addr;
    (pastIo && idr_in16(cycle.addr[15:0], IDR_CFGA_LO, IDR_CFGA_HI))
    |=> decodeTgt.cfgAddr && !decodeTgt.cfgData && !decodeTgt.pciSub;
  endproperty
  a_cfg_addr: assert property (p_cfg_addr)
    else $error("config address port not decoded");

  property p_cfg_data;
    (pastIo && idr_in16(cycle.addr[15:0], IDR_CFGD_LO, IDR_CFGD_HI))
    |=> decodeTgt.cfgData && !decodeTgt.cfgAddr && !decodeTgt.lpc;
  endproperty
  a_cfg_data: assert property (p_cfg_data)
    else $error("config data port not decoded");

  property p_video;
    (cycle.valid && !cycle.isIo)
    |=> decodeTgt.video == ((($past(cycle.addr) >= IDR_VID_LO)
        && ($past(cycle.addr) <= IDR_VID_HI))) && (decodeTgt.dram != decodeTgt.video);
  endproperty
  a_video: assert property (p_video)
    else $error("video window mis-decoded");

  property p_shared_serial;
    (!apicActive && serialS[5] && modeLocked) |=> irqOut[5];
  endproperty
  a_shared_serial: assert property (p_shared_serial)
    else $error("serial irq 5 lost in legacy mode");

  property p_owned;
    // one cycle on, so the first edge after reset never compares against reset-time sources
    1'b1 |=> (irqOut[15:0] & IDR_PIC_RESERVED) == ($past(fixedVec) & IDR_PIC_RESERVED);
  endproperty
  a_owned: assert property (p_owned)
    else $error("owned irq input driven by another source");

  property p_steer_a;
    (modeLocked && !apicActive && lineLevel[0] && !IDR_PIC_RESERVED[pciSteer[0]])
    |=> irqOut[$past(pciSteer[0])];
  endproperty
  a_steer_a: assert property (p_steer_a)
    else $error("line a not steered to its legacy input");

  property p_apic_lines;
    (modeLocked && apicActive)
    |=> irqOut[23:16] == $past(lineLevel)
        && irqOut[15:0] == ($past(fixedVec) | ($past(serialS) & IDR_PIC_SHARED));
  endproperty
  a_apic_lines: assert property (p_apic_lines)
    else $error("apic line delivery wrong");

  property p_gfx_a;
    (modeLocked && apicActive && funcIrq.gfx) |=> irqOut[16];
  endproperty
  a_gfx_a: assert property (p_gfx_a)
    else $error("graphics irq missing on input 16");

  property p_sata_d;
    (modeLocked && apicActive && funcIrq.sata2) |=> irqOut[19] && ($past(lineLevel[3]));
  endproperty
  a_sata_d: assert property (p_sata_d)
    else $error("sata irq missing on input 19");

  property p_line_b;
    (modeLocked && apicActive && (funcIrq.rp1 || funcIrq.rp5)) |=> irqOut[17];
  endproperty
  a_line_b: assert property (p_line_b)
    else $error("root port 1 or 5 irq missing on input 17");

  property p_line_c;
    (modeLocked && apicActive && (funcIrq.rp2 || funcIrq.smbus)) |=> irqOut[18];
  endproperty
  a_line_c: assert property (p_line_c)
    else $error("root port 2 or smbus irq missing on input 18");

  property p_line_egh;
    (modeLocked && apicActive && (funcIrq.lan || funcIrq.hda || funcIrq.ehci1))
    |=> (irqOut[20] || !$past(funcIrq.lan))
        && (irqOut[22] || !$past(funcIrq.hda))
        && (irqOut[23] || !$past(funcIrq.ehci1));
  endproperty
  a_line_egh: assert property (p_line_egh)
    else $error("lan, audio or first ehci irq missing on its input");

  property p_port3_inta;
    (portPresent[4] && msgIntx[4][0]) |-> swzAbcd[3];
  endproperty
  a_port3_inta: assert property (p_port3_inta)
    else $error("port 3 inta not on line d");

  property p_port6_intb;
    (portPresent[7] && msgIntx[7][1]) |-> lineLevel[0];
  endproperty
  a_port6_intb: assert property (p_port6_intb)
    else $error("port 6 intb not rotated onto line a");

  property p_absent_port;
    (portPresent == 8'h00 && msgIntx != '0) |-> swzAbcd == 4'h0;
  endproperty
  a_absent_port: assert property (p_absent_port)
    else $error("message from absent port delivered");

  property p_visible;
    1'b1 |=> portVisible == $past(portPresent);
  endproperty
  a_visible: assert property (p_visible)
    else $error("port visibility does not follow attach state");

  sequence s_lock;
    !modeLocked ##1 modeLocked;
  endsequence

  property p_mode_hold;
    s_lock |=> ($stable(apicActive) && modeLocked)[*8];
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed after lock");

endmodule // idr_io_decode_irq_router
`default_nettype wire

//--- idr_io_decode_irq_router_tb.sv
// idr_io_decode_irq_router_tb: self-checking bench of decode and irq routing
`timescale 1ns/1ns
`default_nettype none
module idr_io_decode_irq_router_tb;
  import idr_pkg::*;

  typedef struct packed {
    logic        vld;
    logic        io;
    logic [31:0] addr;
    logic [5:0]  exp;
  } idr_dec_row_t;

  localparam logic [5:0] LPC = 6'h20, SUB = 6'h10, CFA = 6'h08, CFD = 6'h04;
  localparam logic [5:0] VID = 6'h02, DRM = 6'h01;
  localparam int NROW = 24;
  localparam idr_dec_row_t ROWS [NROW] = '{
    '{1'h1, 1'h1, 32'h0000_03F7, SUB}, '{1'h1, 1'h1, 32'h0000_03F8, LPC},
    '{1'h1, 1'h1, 32'h0000_03FF, LPC}, '{1'h1, 1'h1, 32'h0000_0400, SUB},
    '{1'h1, 1'h1, 32'h0000_03E7, SUB}, '{1'h1, 1'h1, 32'h0000_03E8, LPC},
    '{1'h1, 1'h1, 32'h0000_03EF, LPC}, '{1'h1, 1'h1, 32'h0000_03F0, SUB},
    '{1'h1, 1'h1, 32'h0000_09FF, SUB}, '{1'h1, 1'h1, 32'h0000_0A00, LPC},
    '{1'h1, 1'h1, 32'h0000_0A0F, LPC}, '{1'h1, 1'h1, 32'h0000_0A10, SUB},
    '{1'h1, 1'h1, 32'h0000_0CF7, SUB}, '{1'h1, 1'h1, 32'h0000_0CF8, CFA},
    '{1'h1, 1'h1, 32'h0000_0CFB, CFA}, '{1'h1, 1'h1, 32'h0000_0CFC, CFD},
    '{1'h1, 1'h1, 32'h0000_0CFF, CFD}, '{1'h1, 1'h1, 32'h0001_03F8, LPC},
    '{1'h1, 1'h0, 32'h0009_FFFF, DRM}, '{1'h1, 1'h0, 32'h000A_0000, VID},
    '{1'h1, 1'h0, 32'h000B_FFFF, VID}, '{1'h1, 1'h0, 32'h000C_0000, DRM},
    '{1'h1, 1'h0, 32'h0000_03F8, DRM}, '{1'h0, 1'h1, 32'h0000_03F8, 6'h00}};
  localparam logic [15:0] OWNED = 16'h2307;
  localparam int FIXPOS [6] = '{0, 1, 2, 8, 9, 13};
  // line per function source, gfx first; a=0 .. h=7
  localparam int FUNCLINE [16] = '{0, 7, 0, 2, 3, 3, 4, 6, 3, 0, 1, 2, 3, 0, 1, 3};
  localparam int BASE [8] = '{0, 0, 1, 2, 3, 0, 1, 3};

  ////////////////////////////////////////////////////////////////////////////////
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  idr_cycle_t       cycle = '0;
  logic             decodeValid;
  idr_target_t      decodeTgt;
  logic [15:0]      serialIrqLine;
  logic [7:0]       routedPciLine;
  idr_fixed_irq_t   fixedIrq = '0;
  idr_func_irq_t    funcIrq = '0;
  logic [7:0][3:0]  msgIntx;
  logic [7:0][3:0]  pciSteer = '0;
  logic [7:0]       portPresent;
  logic [7:0]       portVisible;
  logic             apicStrap = 1'b0;
  logic             apicActive;
  logic             modeLocked;
  logic [23:0]      irqOut;
  int               n_mismatch = 0;
  int               check_count = 0;

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  idr_irq_source src (
    .serialIrqLine (serialIrqLine),
    .routedPciLine (routedPciLine),
    .msgIntx       (msgIntx),
    .portPresent   (portPresent)
  );

  idr_io_decode_irq_router dut (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .cycle         (cycle),
    .decodeValid   (decodeValid),
    .decodeTgt     (decodeTgt),
    .serialIrqLine (serialIrqLine),
    .routedPciLine (routedPciLine),
    .fixedIrq      (fixedIrq),
    .funcIrq       (funcIrq),
    .msgIntx       (msgIntx),
    .pciSteer      (pciSteer),
    .portPresent   (portPresent),
    .portVisible   (portVisible),
    .apicStrap     (apicStrap),
    .apicActive    (apicActive),
    .modeLocked    (modeLocked),
    .irqOut        (irqOut)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // the strap is only taken after reset, so each mode needs its own reset
  task automatic do_reset(input logic strap);
    @(negedge ref_clk);
    rst = 1'b1;
    apicStrap = strap;
    src.set_pins(16'h0000, 8'h00);
    src.set_ports(8'h00, '0);
    tick(12);
    check("rstIrq", irqOut, 24'h0);
    check("rstValid", decodeValid, 1'b0);
    check("rstLock", modeLocked, 1'b0);
    rst = 1'b0;
    tick(2);
    check("lockEarly", modeLocked, 1'b0);
    tick(1);
    check("lockSet", modeLocked, 1'b1);
    check("apicMode", apicActive, strap);
  endtask

  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    logic [7:0][3:0] v;
    do_reset(1'b0);
    for (int k = 0; k < NROW; k++) begin
      cycle = '{ROWS[k].vld, ROWS[k].io, ROWS[k].addr};
      tick(1);
      check("decodeValid", decodeValid, ROWS[k].vld);
      check("decodeTgt", decodeTgt, ROWS[k].exp);
    end
    cycle = '0;
    for (int i = 0; i < 6; i++) begin
      fixedIrq = idr_fixed_irq_t'(6'h20 >> i);
      tick(1);
      check("fixedIrq", irqOut, 24'h1 << FIXPOS[i]);
    end
    fixedIrq = '0;
    src.set_pins(16'hFFFF, 8'h00);
    tick(3);
    check("serialLegacy", irqOut[15:0], 16'h1CF8);
    src.set_pins(16'h0000, 8'h00);
    tick(3);
    check("serialClear", irqOut[15:0], 16'h0000);
    funcIrq.rp0 = 1'b1;
    for (int n = 0; n < 16; n++) begin
      pciSteer[0] = 4'(n);
      tick(1);
      check("legacySteer", irqOut[15:0], (16'h0001 << n) & ~OWNED);
    end
    funcIrq = '0;
    pciSteer[5] = 4'hA;
    src.set_pins(16'h0000, 8'h20);
    tick(3);
    check("legacyPin", irqOut[15:0], 16'h0400);
    src.set_pins(16'h0000, 8'h00);

    do_reset(1'b1);
    for (int i = 0; i < 16; i++) begin
      funcIrq = idr_func_irq_t'(16'h8000 >> i);
      tick(1);
      check("apicFunc", irqOut, 24'h1 << (16 + FUNCLINE[i]));
    end
    funcIrq = '0;
    for (int j = 0; j < 8; j++) begin
      src.set_pins(16'h0000, 8'h01 << j);
      tick(3);
      check("apicPin", irqOut, 24'h1 << (16 + j));
    end
    src.set_pins(16'h0000, 8'h00);
    tick(3);
    check("apicPinClear", irqOut, 24'h0);
    for (int p = 0; p < 8; p++) begin
      for (int i = 0; i < 4; i++) begin
        v = '0;
        v[p][i] = 1'b1;
        src.set_ports(8'hFF, v);
        tick(1);
        check("intxSwizzle", irqOut, 24'h1 << (16 + (BASE[p] + i) % 4));
      end
    end
    src.set_ports(8'h00, {8{4'hF}});
    tick(1);
    check("absentIntx", irqOut, 24'h0);
    check("absentPort", portVisible, 8'h00);
    src.set_ports(8'hA5, '0);
    tick(1);
    check("portVisible", portVisible, 8'hA5);
    apicStrap = 1'b0;
    tick(4);
    check("modeHeld", apicActive, 1'b1);
    check("lockHeld", modeLocked, 1'b1);
    finish_test();
  end
endmodule // idr_io_decode_irq_router_tb
`default_nettype wire

//--- idr_io_decoder.sv
// idr_io_decoder: combinational target decode of one host cycle
`timescale 1ns/1ns
`default_nettype none
module idr_io_decoder (
  // cycle in
  input  wire idr_pkg::idr_cycle_t cyc,
  // target out
  output idr_pkg::idr_target_t     tgt
);
  import idr_pkg::*;

  logic lpcHit;
  logic cfgA;
  logic cfgD;

  always_comb begin
    lpcHit = idr_lpc_hit(cyc.addr[15:0]);
    cfgA   = idr_in16(cyc.addr[15:0], IDR_CFGA_LO, IDR_CFGA_HI);
    cfgD   = idr_in16(cyc.addr[15:0], IDR_CFGD_LO, IDR_CFGD_HI);
    tgt    = '0;
    if (cyc.valid && cyc.isIo) begin
      tgt.cfgAddr = cfgA;
      tgt.cfgData = cfgD;
      tgt.lpc     = lpcHit;
      // nothing claimed it positively, so pci takes it subtractively
      tgt.pciSub  = !(lpcHit || cfgA || cfgD);
    end else if (cyc.valid) begin
      tgt.video = (cyc.addr >= IDR_VID_LO) && (cyc.addr <= IDR_VID_HI);
      tgt.dram  = !tgt.video;
    end
  end

endmodule // idr_io_decoder
`default_nettype wire

//--- idr_irq_source.sv
// idr_irq_source: far-side model of pin interrupts and downstream pcie ports
`timescale 1ns/1ns
`default_nettype none
module idr_irq_source (
  // pin levels toward the router
  output var logic [15:0]     serialIrqLine,
  output var logic [7:0]      routedPciLine,
  // downstream port state
  output var logic [7:0][3:0] msgIntx,
  output var logic [7:0]      portPresent
);
  ////////////////////////////////////////////////////////////////////////////////
  // no two-wire target is modelled, so address 16h is left free
  initial begin
    serialIrqLine = 16'h0000;
    routedPciLine = 8'h00;
    msgIntx       = '0;
    portPresent   = 8'h00;
  end

  // pins are asynchronous; the skew keeps them away from the router's clock edge
  task automatic set_pins(input logic [15:0] ser, input logic [7:0] pci);
    #3;
    serialIrqLine = ser;
    routedPciLine = pci;
  endtask

  task automatic set_ports(input logic [7:0] present, input logic [7:0][3:0] intx);
    portPresent = present;
    msgIntx     = intx;
  endtask
endmodule // idr_irq_source
`default_nettype wire

//--- idr_pkg.sv
// idr_pkg: constants, carrier types and helpers for the io decode and irq router
package idr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // io windows forwarded to the low-pin-count bus
  localparam logic [15:0] IDR_LPC0_LO = 16'h03F8;
  localparam logic [15:0] IDR_LPC0_HI = 16'h03FF;
  localparam logic [15:0] IDR_LPC1_LO = 16'h03E8;
  localparam logic [15:0] IDR_LPC1_HI = 16'h03EF;
  localparam logic [15:0] IDR_LPC2_LO = 16'h0A00;
  localparam logic [15:0] IDR_LPC2_HI = 16'h0A0F;
  // pci configuration mechanism ports
  localparam logic [15:0] IDR_CFGA_LO = 16'h0CF8;
  localparam logic [15:0] IDR_CFGA_HI = 16'h0CFB;
  localparam logic [15:0] IDR_CFGD_LO = 16'h0CFC;
  localparam logic [15:0] IDR_CFGD_HI = 16'h0CFF;
  // legacy video memory and firmware window
  localparam logic [31:0] IDR_VID_LO  = 32'h000A_0000;
  localparam logic [31:0] IDR_VID_HI  = 32'h000B_FFFF;

  //////////////////////////////////////////////////////////////////////////////
  // legacy irq inputs: shared (serial or pci), pci only, fixed owners
  localparam logic [15:0] IDR_PIC_SHARED   = 16'h1CF8;
  localparam logic [15:0] IDR_PIC_RESERVED = 16'h2307;
  localparam int IDR_IRQ_TIMER   = 0;
  localparam int IDR_IRQ_KBD     = 1;
  localparam int IDR_IRQ_CASCADE = 2;
  localparam int IDR_IRQ_RTC     = 8;
  localparam int IDR_IRQ_ACPI    = 9;
  localparam int IDR_IRQ_MATH    = 13;
  localparam int IDR_APIC_BASE   = 16;
  localparam int IDR_NLINE       = 8;
  localparam int IDR_NPORT       = 8;
  // first routed line (0=A..3=D) of each downstream port;
  // index 0 graphics port, index 1..7 pcie ports 0..6
  localparam logic [7:0][1:0] IDR_PORT_BASE =
    {2'h3, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
  // edges after reset release before the synchronised strap is taken
  localparam logic [1:0] IDR_STRAP_DLY = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic {IDR_MODE_LEGACY, IDR_MODE_APIC} idr_mode_t;
  localparam idr_mode_t IDR_RST_MODE = IDR_MODE_LEGACY;

  typedef struct packed {
    logic        valid;
    logic        isIo;
    logic [31:0] addr;
  } idr_cycle_t;

  typedef struct packed {
    logic lpc;
    logic pciSub;
    logic cfgAddr;
    logic cfgData;
    logic video;
    logic dram;
  } idr_target_t;

  typedef struct packed {
    logic timer;
    logic kbd;
    logic cascade;
    logic rtc;
    logic acpiControlInterrupt;
    logic math;
  } idr_fixed_irq_t;

  typedef struct packed {
    logic gfx;
    logic ehci1;
    logic ehci2;
    logic smbus;
    logic sata1;
    logic sata2;
    logic lan;
    logic hda;
    logic pegRoot;
    logic rp0;
    logic rp1;
    logic rp2;
    logic rp3;
    logic rp4;
    logic rp5;
    logic rp7;
  } idr_func_irq_t;

  function automatic logic idr_in16(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic idr_lpc_hit(input logic [15:0] a);
    return idr_in16(a, IDR_LPC0_LO, IDR_LPC0_HI) ||
           idr_in16(a, IDR_LPC1_LO, IDR_LPC1_HI) ||
           idr_in16(a, IDR_LPC2_LO, IDR_LPC2_HI);
  endfunction

endpackage
